//--- hw/pcx_top.sv
// Operation
// - Analog pin: no pull-up, driver, receiver
// - Input kind bit one digital, zero analog
// - Reset leaves every pin digital input
// - Drive bit zero open-drain, one push-pull
// - SMBus pins always open-drain
// - Pull-ups on open-drain pins unless disabled
// - Pull-up disable ignores push-pull pins
// - Pull-up off while pin drives low
// - Enable bit turns on peripheral routing
// - Disabled crossbar: pins are plain inputs
// - Disabled crossbar: all drivers off
// - Bypassed pins skipped by routing
//
// Our own choices: the register offsets and the APB slave port.
`timescale 1ns/1ps
module pcx_top (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [pcx_pkg::NALL-1:0] pin_in,
   output logic [pcx_pkg::NALL-1:0] pin_out,
   output logic [pcx_pkg::NALL-1:0] pin_oe,
   output logic [pcx_pkg::NALL-1:0] pin_pullup,
   output logic [pcx_pkg::NALL-1:0] pin_rx_en,
   input wire logic [pcx_pkg::NPERIPH-1:0] periph_out,
   input wire logic [pcx_pkg::NPERIPH-1:0] periph_oe,
   output logic [pcx_pkg::NPERIPH-1:0] periph_in
);
   localparam int N = pcx_pkg::NPINS;
   localparam int NA = pcx_pkg::NALL;
   localparam int PW = pcx_pkg::PIDX_W;

   // Configuration registers
   logic [NA-1:0] pin_input_kind_reg_ff;   // One bit per pin, 1 digital
   logic [N-1:0] pin_output_drive_reg_ff;  // Ports 0 and 1 drive mode
   logic [1:0] port2_output_drive_select_ff; // Port 2 drive mode
   logic [N-1:0] pin_bypass_reg_ff;        // Skip flags
   logic [7:0] peripheral_route_sel_a_ff;  // Peripheral requests
   logic [7:0] peripheral_route_sel_b_ff;  // Holds pull-up disable
   logic [7:0] peripheral_route_sel_c_ff;  // Holds crossbar enable
   logic [NA-1:0] gpio_latch_ff;           // Port output latch
   logic [NA-1:0] pin_sync;                // Synchronised pin levels

   logic weak_pullup_disable;
   logic switch_matrix_enable;
   logic [NA-1:0] drive_pp;     // Effective push-pull per pin
   logic [N-1:0] route_hit;
   logic [N*PW-1:0] route_sel;
   logic [NA-1:0] hit_all; // Routing hit widened to every pin
   logic [NA*PW-1:0] sel_all; // Routing selects widened to every pin
   logic [NA-1:0] nxt_pin_out, nxt_pin_oe, nxt_pin_pullup, nxt_rx;
   logic [pcx_pkg::NPERIPH-1:0] nxt_periph_in;
   logic wr_en, rd_en;
   logic [31:0] nxt_prdata;

   assign weak_pullup_disable =
      peripheral_route_sel_b_ff[pcx_pkg::WEAK_PULLUP_DISABLE_BIT];
   assign switch_matrix_enable =
      peripheral_route_sel_c_ff[pcx_pkg::XEN_BIT];

   // Pin levels come from outside, so they are synchronised first
   pcx_sync #(.W(NA)) u_sync (
      .pclk(pclk),
      .presetn(presetn),
      .d(pin_in),
      .q(pin_sync)
   );

   // Only peripherals in the low six bits of route select a and the low two of b are routed
   pcx_route u_route (
      .bypass(pin_bypass_reg_ff),
      .req({peripheral_route_sel_b_ff[1:0],
            peripheral_route_sel_a_ff[5:0]}),
      .hit(route_hit),
      .sel(route_sel)
   );

   // Port 2 pins are never routed; widening keeps every index in range
   assign hit_all = {{(NA-N){1'b0}}, route_hit};
   assign sel_all = {{((NA-N)*PW){1'b0}}, route_sel};

   // Slave answers in the access phase with no wait states
   assign wr_en = psel && penable && pwrite;
   assign rd_en = psel && !penable && !pwrite;

   // Byte-field helper used by the route select register writes
   function automatic logic [7:0] wbyte(input logic [31:0] d);
      return d[7:0];
   endfunction

   // Input kind register; reset makes all pins digital
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_input_kind_reg_ff <= pcx_pkg::INKIND_RST;
      end else if (wr_en && paddr == pcx_pkg::OFF_INKIND) begin
         pin_input_kind_reg_ff <= pwdata[NA-1:0];
      end
   end

   // Drive mode registers for ports 0, 1 and 2
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_output_drive_reg_ff <= '0;
         port2_output_drive_select_ff <= pcx_pkg::P2_RST;
      end else if (wr_en && paddr == pcx_pkg::OFF_DRIVE) begin
         pin_output_drive_reg_ff <= pwdata[N-1:0];
      end else if (wr_en && paddr == pcx_pkg::OFF_P2_DRIVE) begin
         // Reserved upper bits are not stored and read back zero
         port2_output_drive_select_ff <= pwdata[1:0];
      end
   end

   // Skip flags
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_bypass_reg_ff <= '0;
      end else if (wr_en && paddr == pcx_pkg::OFF_BYPASS) begin
         pin_bypass_reg_ff <= pwdata[N-1:0];
      end
   end

   // Peripheral route selects, enable and pull-up disable bits
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         peripheral_route_sel_a_ff <= pcx_pkg::BYTE_RST;
         peripheral_route_sel_b_ff <= pcx_pkg::BYTE_RST;
         peripheral_route_sel_c_ff <= pcx_pkg::BYTE_RST;
      end else if (wr_en) begin
         if (paddr == pcx_pkg::OFF_ROUTE_A) begin
            peripheral_route_sel_a_ff <= wbyte(pwdata);
         end else if (paddr == pcx_pkg::OFF_ROUTE_B) begin
            peripheral_route_sel_b_ff <= wbyte(pwdata);
         end else if (paddr == pcx_pkg::OFF_ROUTE_C) begin
            peripheral_route_sel_c_ff <= wbyte(pwdata);
         end
      end
   end

   // General-purpose output latch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         gpio_latch_ff <= pcx_pkg::ZERO_RST;
      end else if (wr_en && paddr == pcx_pkg::OFF_PIN_OUT) begin
         gpio_latch_ff <= pwdata[NA-1:0];
      end
   end

   // Effective drive mode; SMBus pins forced open-drain
   always_comb begin
      drive_pp = {port2_output_drive_select_ff, pin_output_drive_reg_ff};
      for (int p = 0; p < N; p++) begin
         if (switch_matrix_enable && route_hit[p] &&
             (route_sel[p*PW +: PW] == PW'(pcx_pkg::SDA_IDX) ||
              route_sel[p*PW +: PW] == PW'(pcx_pkg::SCL_IDX))) begin
            drive_pp[p] = 1'b0;
         end
      end
   end

   // Pin driver, pull-up and receiver control
   always_comb begin
      nxt_periph_in = '0;
      for (int p = 0; p < NA; p++) begin
         // Default: port latch drives the pin
         nxt_pin_out[p] = gpio_latch_ff[p];
         nxt_pin_oe[p] = drive_pp[p] || !gpio_latch_ff[p];
         if (switch_matrix_enable && hit_all[p]) begin
            nxt_pin_out[p] = periph_out[sel_all[p*PW +: PW]];
            nxt_pin_oe[p] = periph_oe[sel_all[p*PW +: PW]] &&
               (drive_pp[p] || !nxt_pin_out[p]);
         end
         if (!switch_matrix_enable) begin
            nxt_pin_oe[p] = 1'b0;
         end
         nxt_rx[p] = pin_input_kind_reg_ff[p];
         // Pull-up only on open-drain, not disabled, not driving low
         nxt_pin_pullup[p] = !drive_pp[p] && !weak_pullup_disable
            && !(nxt_pin_oe[p] && !nxt_pin_out[p]);
         if (!pin_input_kind_reg_ff[p]) begin
            nxt_pin_oe[p] = 1'b0;
            nxt_pin_pullup[p] = 1'b0;
         end
      end
      // Peripheral inputs only see their pin while routed
      for (int p = 0; p < N; p++) begin
         if (switch_matrix_enable && route_hit[p] &&
             pin_input_kind_reg_ff[p]) begin
            nxt_periph_in[route_sel[p*PW +: PW]] = pin_sync[p];
         end
      end
   end

   // Registered pin-side outputs
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_out <= '0;
         pin_oe <= '0;
         pin_pullup <= '0;
         // Receivers start on, matching the all-digital reset kind
         pin_rx_en <= pcx_pkg::INKIND_RST;
         periph_in <= '0;
      end else begin
         pin_out <= nxt_pin_out;
         pin_oe <= nxt_pin_oe;
         pin_pullup <= nxt_pin_pullup;
         pin_rx_en <= nxt_rx;
         periph_in <= nxt_periph_in;
      end
   end

   // Read mux; analog pins read zero since their receiver is off
   always_comb begin
      nxt_prdata = pcx_pkg::RD_ZERO;
      if (paddr == pcx_pkg::OFF_INKIND) begin
         nxt_prdata[NA-1:0] = pin_input_kind_reg_ff;
      end else if (paddr == pcx_pkg::OFF_DRIVE) begin
         nxt_prdata[N-1:0] = pin_output_drive_reg_ff;
      end else if (paddr == pcx_pkg::OFF_BYPASS) begin
         nxt_prdata[N-1:0] = pin_bypass_reg_ff;
      end else if (paddr == pcx_pkg::OFF_ROUTE_A) begin
         nxt_prdata[7:0] = peripheral_route_sel_a_ff;
      end else if (paddr == pcx_pkg::OFF_ROUTE_B) begin
         nxt_prdata[7:0] = peripheral_route_sel_b_ff;
      end else if (paddr == pcx_pkg::OFF_ROUTE_C) begin
         nxt_prdata[7:0] = peripheral_route_sel_c_ff;
      end else if (paddr == pcx_pkg::OFF_P2_DRIVE) begin
         nxt_prdata[1:0] = port2_output_drive_select_ff;
      end else if (paddr == pcx_pkg::OFF_PIN_OUT) begin
         nxt_prdata[NA-1:0] = gpio_latch_ff;
      end else if (paddr == pcx_pkg::OFF_PIN_IN) begin
         nxt_prdata[NA-1:0] = pin_sync & pin_input_kind_reg_ff;
      end
   end

   // Read data captured in setup; pready low in reset, high from the first edge after, no errors
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata <= pcx_pkg::RD_ZERO;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else begin
         pready <= 1'b1;
         pslverr <= 1'b0;
         if (rd_en) begin
            prdata <= nxt_prdata;
         end
      end
   end

   // Analog pin 0 never drives or pulls up
   a_analog_quiet: assert property (
      @(posedge pclk) disable iff (!presetn)
      !$past(pin_input_kind_reg_ff[0]) |-> !pin_oe[0] && !pin_pullup[0])
      else $error("analog pin active");
   // Receiver enable tracks the input kind one cycle later
   a_rx_follows_kind: assert property (
      @(posedge pclk) disable iff (!presetn)
      pin_rx_en == $past(pin_input_kind_reg_ff))
      else $error("receiver not following kind");
   a_reset_digital: assert property (
      @(posedge pclk)
      $rose(presetn) |-> pin_input_kind_reg_ff == pcx_pkg::INKIND_RST)
      else $error("pins not digital after reset");
   // Pin 8 is open-drain GPIO with a high latch, so this is exercised
   a_od_no_high: assert property (
      @(posedge pclk) disable iff (!presetn)
      !$past(drive_pp[8]) |-> !(pin_oe[8] && pin_out[8]))
      else $error("open drain drove high");
   a_pullup_od: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(drive_pp[8] || weak_pullup_disable) |-> !pin_pullup[8])
      else $error("pull-up on wrong pin");
   a_pullup_low: assert property (
      @(posedge pclk) disable iff (!presetn)
      pin_oe[9] && !pin_out[9] |-> !pin_pullup[9])
      else $error("pull-up while low");
   // Routed SMBus data pin only ever pulls low
   a_smbus_od: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(switch_matrix_enable && hit_all[5] &&
         sel_all[5*PW +: PW] == PW'(pcx_pkg::SDA_IDX))
      |-> !(pin_oe[5] && pin_out[5]))
      else $error("SMBus pin drove high");
   // Unrouted port 2 pin follows its latch once the crossbar is on
   a_gpio_drive: assert property (
      @(posedge pclk) disable iff (!presetn)
      $past(switch_matrix_enable && pin_input_kind_reg_ff[16]) |->
      pin_out[16] == $past(gpio_latch_ff[16]) &&
      pin_oe[16] == $past(drive_pp[16] || !gpio_latch_ff[16]))
      else $error("port latch not driving pin");
   sequence s_xbar_off;
      !switch_matrix_enable ##1 1'b1;
   endsequence
   a_off_drivers: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_xbar_off |-> pin_oe == '0)
      else $error("driver on while crossbar off");
   a_off_periph: assert property (
      @(posedge pclk) disable iff (!presetn)
      s_xbar_off |-> periph_in == '0)
      else $error("peripheral routed while off");
   a_skip_pin0: assert property (
      @(posedge pclk) disable iff (!presetn)
      pin_bypass_reg_ff[0] |-> !route_hit[0])
      else $error("skipped pin routed");
endmodule

//--- hw/pcx_pkg.sv
package pcx_pkg;
   // Port geometry
   localparam int NPINS = 16;             // Pins of ports 0 and 1
   localparam int NP2 = 2;                // Pins of port 2
   localparam int NALL = NPINS + NP2;     // Total pins
   localparam int NPERIPH = 8;            // Routable peripheral signals
   localparam int PIDX_W = 3;             // Width of a peripheral index

   // Register byte offsets
   localparam logic [11:0] OFF_INKIND = 12'h000;
   localparam logic [11:0] OFF_DRIVE = 12'h004;
   localparam logic [11:0] OFF_BYPASS = 12'h008;
   localparam logic [11:0] OFF_ROUTE_A = 12'h00c;
   localparam logic [11:0] OFF_ROUTE_B = 12'h010;
   localparam logic [11:0] OFF_ROUTE_C = 12'h014;
   localparam logic [11:0] OFF_P2_DRIVE = 12'h018;
   localparam logic [11:0] OFF_PIN_OUT = 12'h01c;
   localparam logic [11:0] OFF_PIN_IN = 12'h020;

   // Field positions
   localparam int WEAK_PULLUP_DISABLE_BIT = 7;        // In route select b
   localparam int XEN_BIT = 6;            // In route select c
   localparam int SDA_IDX = 2;            // Peripheral index of SMBus data
   localparam int SCL_IDX = 3;            // Peripheral index of SMBus clock

   // Reset values
   localparam logic [NALL-1:0] INKIND_RST = '1;   // All digital inputs
   localparam logic [NALL-1:0] ZERO_RST = '0;
   localparam logic [7:0] BYTE_RST = 8'h00;
   localparam logic [NP2-1:0] P2_RST = '0;
   localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

//--- hw/pcx_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for the pin input bus
module pcx_sync #(
   parameter int W = 18
) (
   input wire logic pclk,
   input wire logic presetn,
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta_ff; // First stage, read only by q

   // Both stages clear at reset to a constant
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         meta_ff <= '0;
         q <= '0;
      end else begin
         meta_ff <= d;
         q <= meta_ff;
      end
   end
endmodule

//--- hw/pcx_route.sv
`timescale 1ns/1ps
// Crossbar priority: the k-th requesting peripheral goes to the k-th free pin
module pcx_route (
   input wire logic [pcx_pkg::NPINS-1:0] bypass,
   input wire logic [pcx_pkg::NPERIPH-1:0] req,
   output logic [pcx_pkg::NPINS-1:0] hit,
   output logic [pcx_pkg::NPINS*pcx_pkg::PIDX_W-1:0] sel
);
   // Walk pins upward; lowest peripheral number has priority
   always_comb begin
      logic [pcx_pkg::NPERIPH-1:0] left;
      left = req;
      hit = '0;
      sel = '0;
      for (int p = 0; p < pcx_pkg::NPINS; p++) begin
         if (!bypass[p]) begin
            for (int k = 0; k < pcx_pkg::NPERIPH; k++) begin
               if (left[k] && !hit[p]) begin
                  hit[p] = 1'b1;
                  sel[p*pcx_pkg::PIDX_W +: pcx_pkg::PIDX_W] =
                     k[pcx_pkg::PIDX_W-1:0];
                  left[k] = 1'b0;
               end
            end
         end
      end
   end
endmodule

//--- dv/port_crossbar_config_test.sv
`timescale 1ns/1ps
// Self-checking bench: APB register traffic plus pin and peripheral checks
module port_crossbar_config_test;
   logic pclk; // Bus clock
   logic presetn; // Async reset, low active
   logic psel; // APB select
   logic penable; // APB access phase
   logic pwrite; // APB direction
   logic [11:0] paddr; // APB byte address
   logic [31:0] pwdata; // APB write data
   logic [31:0] prdata; // APB read data
   logic pready; // APB answer
   logic pslverr; // APB error, checked low after reset
   logic [17:0] pin_in; // External pin levels
   logic [17:0] pin_out; // Pin output values
   logic [17:0] pin_oe; // Pin drivers on
   logic [17:0] pin_pullup; // Weak pull-ups on
   logic [17:0] pin_rx_en; // Digital receivers on
   logic [7:0] periph_out; // Peripheral output values
   logic [7:0] periph_oe; // Peripheral output enables
   logic [7:0] periph_in; // Levels routed to peripherals
   int bad_count; // Mismatches seen
   int cmp_count; // Comparisons made
   logic [31:0] rd; // Last word read
   logic [17:0] exp_oe; // Expected driver map for GPIO use

   // Pins 0..3 stay analog, pin 16 push-pull, latch pattern below
   localparam logic [17:0] IK = 18'h3fff0;
   localparam logic [17:0] PP = 18'h100f0;
   localparam logic [17:0] LAT = 18'h2a5a5;

   pcx_top pcx_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .pin_in(pin_in),
      .pin_out(pin_out), .pin_oe(pin_oe), .pin_pullup(pin_pullup),
      .pin_rx_en(pin_rx_en), .periph_out(periph_out),
      .periph_oe(periph_oe), .periph_in(periph_in));

   // 100 MHz clock
   initial begin
      pclk = 1'b0;
      forever #5 pclk = ~pclk;
   end

   // Counts, verdict and end of run
   task automatic tally_and_finish();
      $display("Comparisons %0d, mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   // One APB transfer; an idle edge always precedes the setup cycle
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] wd, output logic [31:0] rdv);
      int n;
      n = 0;
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      // Bounded wait so a dead slave cannot hang the run
      while (pready !== 1'b1 && n < 20) begin
         n++;
         @(posedge pclk);
      end
      if (n >= 20) begin
         bad_count++;
         $display("[ERR] t=%0t pready got %h exp %h", $time, pready, 1'b1);
         tally_and_finish();
      end
      rdv = prdata;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask

   // Register write
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      apb(1'b1, a, d, rd);
   endtask

   // Register read compared with an expected word
   task automatic chk_reg(input logic [11:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0000_0000, rd);
      cmp_count++;
      if (rd !== e) begin
         bad_count++;
         $display("[ERR] t=%0t reg %h got %h exp %h", $time, a, rd, e);
      end
   endtask

   // Pin-side vector compare
   task automatic chk_pin(input logic [17:0] g, input logic [17:0] e);
      cmp_count++;
      if (g !== e) begin
         bad_count++;
         $display("[ERR] t=%0t pins got %h exp %h", $time, g, e);
      end
   endtask

   // Covers the register stage plus the two-flop input synchroniser
   task automatic settle();
      repeat (4) @(posedge pclk);
      #1;
   endtask

   initial begin
      presetn = 1'b0;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0000_0000;
      pin_in = 18'h3ffff;
      periph_out = 8'h01;
      periph_oe = 8'hff;
      bad_count = 0;
      cmp_count = 0;
      repeat (4) @(posedge pclk);
      presetn <= 1'b1;
      @(posedge pclk);
      // Reset values, then an unmapped place
      chk_reg(pcx_pkg::OFF_INKIND, 32'h0003_ffff);
      for (int i = 1; i < 8; i++) begin
         chk_reg(12'(i * 4), 32'h0000_0000);
      end
      chk_reg(pcx_pkg::OFF_PIN_IN, 32'h0003_ffff);
      wr(12'h030, 32'hffff_ffff);
      chk_reg(12'h030, 32'h0000_0000);
      chk_pin({17'h0, pslverr}, 18'h00000);
      settle();
      chk_pin(pin_rx_en, 18'h3ffff);
      chk_pin(pin_oe, 18'h00000);
      $display("test reset done");
      // Analog pins lose receiver and pull-up and read as zero
      wr(pcx_pkg::OFF_INKIND, {14'h0, IK});
      settle();
      chk_pin(pin_rx_en, IK);
      chk_pin(pin_pullup & ~IK, 18'h00000);
      chk_reg(pcx_pkg::OFF_PIN_IN, {14'h0, IK});
      $display("test analog done");
      // Configured but disabled: no drivers, nothing routed
      wr(pcx_pkg::OFF_DRIVE, {16'h0, PP[15:0]});
      wr(pcx_pkg::OFF_P2_DRIVE, 32'h0000_0001);
      chk_reg(pcx_pkg::OFF_P2_DRIVE, 32'h0000_0001);
      wr(pcx_pkg::OFF_PIN_OUT, {14'h0, LAT});
      wr(pcx_pkg::OFF_ROUTE_A, 32'h0000_000d);
      settle();
      chk_pin(pin_oe, 18'h00000);
      chk_pin({10'h0, periph_in}, 18'h00000);
      $display("test disabled done");
      // Enabled with no peripherals: plain GPIO drive and pull-ups
      wr(pcx_pkg::OFF_ROUTE_A, 32'h0000_0000);
      wr(pcx_pkg::OFF_ROUTE_C, 32'h0000_0040);
      settle();
      exp_oe = IK & (PP | ~LAT);
      chk_pin(pin_oe, exp_oe);
      chk_pin(pin_out & exp_oe, LAT & exp_oe);
      chk_pin(pin_pullup, IK & ~PP & LAT);
      wr(pcx_pkg::OFF_ROUTE_B, 32'h0000_0080);
      settle();
      chk_pin(pin_pullup, 18'h00000);
      chk_pin(pin_oe, exp_oe);
      $display("test gpio done");
      // Routing past bypassed pins 0..3: periph 0, 2, 3 on pins 4, 5, 6
      // Crossbar off while reconfiguring, enable written last
      wr(pcx_pkg::OFF_ROUTE_C, 32'h0000_0000);
      wr(pcx_pkg::OFF_DRIVE, 32'h0000_ffff);
      wr(pcx_pkg::OFF_BYPASS, 32'h0000_000f);
      wr(pcx_pkg::OFF_ROUTE_A, 32'h0000_000d);
      wr(pcx_pkg::OFF_ROUTE_B, 32'h0000_0000);
      wr(pcx_pkg::OFF_ROUTE_C, 32'h0000_0040);
      settle();
      chk_pin(pin_oe & 18'h00070, 18'h00070);
      chk_pin(pin_out & 18'h00070, 18'h00010);
      chk_pin(pin_pullup & 18'h00070, 18'h00000);
      @(posedge pclk);
      periph_out <= 8'h0c;
      pin_in <= 18'h3ffef;
      settle();
      chk_pin(pin_oe & 18'h00070, 18'h00010);
      chk_pin(pin_pullup & 18'h00070, 18'h00060);
      chk_pin(pin_out & 18'h00010, 18'h00000);
      chk_pin({10'h0, periph_in}, 18'h0000c);
      // Turning the crossbar off again drops every driver
      wr(pcx_pkg::OFF_ROUTE_C, 32'h0000_0000);
      settle();
      chk_pin(pin_oe, 18'h00000);
      chk_pin({10'h0, periph_in}, 18'h00000);
      $display("test routing done");
      // Second reset in mid-run
      @(posedge pclk);
      presetn <= 1'b0;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      chk_reg(pcx_pkg::OFF_INKIND, 32'h0003_ffff);
      chk_reg(pcx_pkg::OFF_ROUTE_A, 32'h0000_0000);
      $display("test rereset done");
      tally_and_finish();
   end
endmodule
